// ===== design/scfd_defines.svh
// Bit positions, reset values and timing counts of the configuration frame
`ifndef SCFD_DEFINES_SVH
`define SCFD_DEFINES_SVH
`define SCFD_FRAME_BITS 64
`define SCFD_CNT_W 7
`define SCFD_CNT_LAST 7'h3f
`define SCFD_CNT_FULL 7'h40
`define SCFD_BIT_CLAMP_ON 50
`define SCFD_BIT_CLAMP_REF 49
`define SCFD_BIT_CLAMP_SHAPE 48
`define SCFD_BIT_FAULT_WIPE 47
`define SCFD_CCS_HI 46
`define SCFD_CCS_LO 43
`define SCFD_GAIN_HI 42
`define SCFD_GAIN_LO 40
`define SCFD_CAP_HI 39
`define SCFD_CAP_LO 34
`define SCFD_MCP_HI 33
`define SCFD_MCP_LO 32
`define SCFD_BIT_HB_TH 31
`define SCFD_RCP_HI 30
`define SCFD_RCP_LO 24
`define SCFD_BIT_SYNC 23
`define SCFD_BGP_HI 22
`define SCFD_BGP_LO 16
`define SCFD_BIT_CB1 15
`define SCFD_BIT_CB0 14
`define SCFD_HBFT_HI 12
`define SCFD_HBFT_LO 11
`define SCFD_RPP_HI 10
`define SCFD_RPP_LO 8
`define SCFD_BIT_FET_B 7
`define SCFD_BIT_FET_A 6
`define SCFD_CAP_RST 6'h3f
`define SCFD_RCP_MIN_ILLEGAL 7'h18
`define SCFD_RCP_MIN_LEGAL 7'h19
`endif

// ===== design/scfd_pkg.sv
// Types shared by the configuration frame decoder
package scfd_pkg;
    typedef struct packed {
        logic clamp_on;
        logic clamp_ref_pick;
        logic clamp_range_shape;
        logic [3:0] clean_current_pick;
        logic [2:0] scaling_gain_pick;
        logic [5:0] comp_capacitance_code;
        logic [1:0] meas_clock_period_code;
        logic heater_batt_threshold_pick;
        logic [6:0] refcell_pulse_len;
        logic [6:0] bandgap_pulse_len;
        logic [2:0] refpin_pulse_len;
    } scfd_cfg_t;
    typedef enum logic [1:0] {
        SCFD_FREE_RUN,
        SCFD_SYNC_IDLE,
        SCFD_SYNC_RUN
    } scfd_mode_t;
endpackage

// ===== design/scfd_frame_decode.sv
// Serial configuration frame decoder with deferred field application
`timescale 1ns/1ns
`include "scfd_defines.svh"

module scfd_frame_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic chip_select_low,
    input wire logic sdi,
    input wire logic cycle_start,
    input wire logic pump_current_source,
    input wire logic sync_input,
    input wire logic sensor_batt_short,
    output logic sdo,
    output scfd_pkg::scfd_cfg_t applied_cfg,
    output scfd_pkg::scfd_cfg_t readback_cfg,
    output logic [1:0] heater_batt_fault_time,
    output logic sync_mode_select,
    output logic protect_fet_a_on,
    output logic protect_fet_b_on,
    output logic fault_wipe,
    output logic confirm_error,
    output logic cycle_abort,
    output logic sync_cycle_start
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    // Pump, sync and short pins all come from outside the clock domain
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end else begin
            pin_s1_reg <= {pump_current_source, sync_input, sensor_batt_short};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic pump_on;
    logic sync_lvl;
    logic batt_short;
    assign pump_on = pin_s2_reg[2];
    assign sync_lvl = pin_s2_reg[1];
    assign batt_short = pin_s2_reg[0];

    // ------------------------------------------------------------
    // Serial clock domain: shift register and frame capture
    // ------------------------------------------------------------
    logic [`SCFD_FRAME_BITS-1:0] shift_reg;
    logic [`SCFD_CNT_W-1:0] bit_cnt_reg;
    logic [`SCFD_FRAME_BITS-1:0] frame_reg;
    logic frame_tgl_reg;
    logic [`SCFD_FRAME_BITS-1:0] echo_reg;
    logic sdo_reg;
    logic [`SCFD_FRAME_BITS-1:0] shift_next;
    assign shift_next = {shift_reg[`SCFD_FRAME_BITS-2:0], sdi};
    logic [5:0] out_idx;
    // Bit 63-k of the echo leaves on serial rise k, most significant first
    assign out_idx = 6'h3f - bit_cnt_reg[5:0];

    // The serial clock stops between frames, so the bit count is cleared
    // by chip select itself rather than by a clock edge after the frame.
    always_ff @(posedge sclk or posedge chip_select_low) begin
        if (chip_select_low) begin
            bit_cnt_reg <= 7'h00;
        end else if (bit_cnt_reg != `SCFD_CNT_FULL) begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 64'h0;
            frame_reg <= 64'h0;
            frame_tgl_reg <= 1'b0;
            sdo_reg <= 1'b0;
        end else if (!chip_select_low) begin
            shift_reg <= shift_next;
            sdo_reg <= echo_reg[out_idx];
            // Only a complete frame is handed over
            if (bit_cnt_reg == `SCFD_CNT_LAST) begin
                frame_reg <= shift_next;
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end
    assign sdo = sdo_reg;

    // ------------------------------------------------------------
    // Frame arrival crossing; acted on once chip select is high
    // ------------------------------------------------------------
    logic [2:0] tgl_sync_reg;
    logic [1:0] cs_sync_reg;
    logic got_frame_reg;
    logic frame_new;
    assign frame_new = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tgl_sync_reg <= 3'h0;
            cs_sync_reg <= 2'h3;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
            cs_sync_reg <= {cs_sync_reg[0], chip_select_low};
        end
    end

    // A new arrival wins over the clear that chip select would give
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            got_frame_reg <= 1'b0;
        end else if (frame_new) begin
            got_frame_reg <= 1'b1;
        end else if (cs_sync_reg[1]) begin
            got_frame_reg <= 1'b0;
        end
    end
    logic frame_take;
    // Frame_reg is stable here: the toggle has crossed and chip select
    // is high, so no serial edge is expected until the next frame.
    assign frame_take = got_frame_reg & cs_sync_reg[1];

    // ------------------------------------------------------------
    // Pending configuration, decoded from each accepted frame
    // ------------------------------------------------------------
    scfd_pkg::scfd_cfg_t pend_reg;
    logic [1:0] hbft_reg;
    logic sync_reg;
    logic fet_a_en_reg;
    logic fet_b_en_reg;
    logic wipe_reg;
    logic cb_err_reg;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_reg <= '0;
            pend_reg.comp_capacitance_code <= `SCFD_CAP_RST;
        end else if (frame_take) begin
            // Bit 13 and bits 5..0 are never looked at
            pend_reg.clamp_on <= frame_reg[`SCFD_BIT_CLAMP_ON];
            if (!pump_on) begin
                pend_reg.clamp_ref_pick <= frame_reg[`SCFD_BIT_CLAMP_REF];
                pend_reg.clamp_range_shape <=
                    frame_reg[`SCFD_BIT_CLAMP_SHAPE];
                pend_reg.comp_capacitance_code <=
                    frame_reg[`SCFD_CAP_HI:`SCFD_CAP_LO];
            end
            pend_reg.clean_current_pick <=
                frame_reg[`SCFD_CCS_HI:`SCFD_CCS_LO];
            pend_reg.scaling_gain_pick <=
                frame_reg[`SCFD_GAIN_HI:`SCFD_GAIN_LO];
            pend_reg.meas_clock_period_code <=
                frame_reg[`SCFD_MCP_HI:`SCFD_MCP_LO];
            pend_reg.heater_batt_threshold_pick <=
                frame_reg[`SCFD_BIT_HB_TH];
            pend_reg.refcell_pulse_len <=
                frame_reg[`SCFD_RCP_HI:`SCFD_RCP_LO];
            pend_reg.bandgap_pulse_len <=
                frame_reg[`SCFD_BGP_HI:`SCFD_BGP_LO];
            pend_reg.refpin_pulse_len <=
                frame_reg[`SCFD_RPP_HI:`SCFD_RPP_LO];
        end
    end

    // Levels that act at once rather than at the next cycle start
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hbft_reg <= 2'h0;
            sync_reg <= 1'b0;
            fet_a_en_reg <= 1'b0;
            fet_b_en_reg <= 1'b0;
        end else if (frame_take) begin
            hbft_reg <= frame_reg[`SCFD_HBFT_HI:`SCFD_HBFT_LO];
            sync_reg <= frame_reg[`SCFD_BIT_SYNC];
            fet_a_en_reg <= frame_reg[`SCFD_BIT_FET_A];
            fet_b_en_reg <= frame_reg[`SCFD_BIT_FET_B];
        end
    end

    // One-cycle pulse: fault wipe
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wipe_reg <= 1'b0;
        end else begin
            wipe_reg <= frame_take & frame_reg[`SCFD_BIT_FAULT_WIPE];
        end
    end

    // One-cycle pulse: a wrong pattern points at stuck or open lines
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cb_err_reg <= 1'b0;
        end else begin
            cb_err_reg <= frame_take & (!frame_reg[`SCFD_BIT_CB1] |
                frame_reg[`SCFD_BIT_CB0]);
        end
    end

    // ------------------------------------------------------------
    // Measurement mode: free running or waiting on sync edges
    // ------------------------------------------------------------
    scfd_pkg::scfd_mode_t mode_reg;
    logic sync_prev_reg;
    logic abort_reg;
    logic sync_start_reg;
    logic sync_rise;
    assign sync_rise = sync_lvl & ~sync_prev_reg;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= scfd_pkg::SCFD_FREE_RUN;
            sync_prev_reg <= 1'b0;
            abort_reg <= 1'b0;
            sync_start_reg <= 1'b0;
        end else begin
            sync_prev_reg <= sync_lvl;
            abort_reg <= 1'b0;
            sync_start_reg <= 1'b0;
            case (mode_reg)
                scfd_pkg::SCFD_FREE_RUN: begin
                    if (sync_reg) begin
                        mode_reg <= scfd_pkg::SCFD_SYNC_IDLE;
                        abort_reg <= 1'b1;
                    end
                end
                scfd_pkg::SCFD_SYNC_IDLE: begin
                    if (!sync_reg) begin
                        mode_reg <= scfd_pkg::SCFD_FREE_RUN;
                    end else if (sync_rise) begin
                        mode_reg <= scfd_pkg::SCFD_SYNC_RUN;
                        sync_start_reg <= 1'b1;
                    end
                end
                scfd_pkg::SCFD_SYNC_RUN: begin
                    if (!sync_reg) begin
                        mode_reg <= scfd_pkg::SCFD_FREE_RUN;
                    end else if (sync_rise) begin
                        sync_start_reg <= 1'b1;
                    end
                end
                default: begin
                    mode_reg <= scfd_pkg::SCFD_FREE_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Applied copy: pending values take effect at cycle start
    // ------------------------------------------------------------
    logic start_now;
    // In sync mode only the sync edge starts a cycle
    assign start_now = sync_reg ? sync_start_reg : cycle_start;
    scfd_pkg::scfd_cfg_t appl_reg;
    scfd_pkg::scfd_cfg_t appl_next;
    scfd_pkg::scfd_cfg_t rb_reg;
    always_comb begin
        appl_next = pend_reg;
        if (sync_reg) begin
            appl_next.meas_clock_period_code = 2'h0;
        end
        // Codes too short to be legal are lifted, zero still disables
        if (pend_reg.refcell_pulse_len != 7'h00 &&
            pend_reg.refcell_pulse_len <= `SCFD_RCP_MIN_ILLEGAL) begin
            appl_next.refcell_pulse_len = `SCFD_RCP_MIN_LEGAL;
        end
    end
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            appl_reg <= '0;
            appl_reg.comp_capacitance_code <= `SCFD_CAP_RST;
            rb_reg <= '0;
            rb_reg.comp_capacitance_code <= `SCFD_CAP_RST;
        end else if (start_now) begin
            appl_reg <= appl_next;
            rb_reg <= pend_reg;
            if (sync_reg) begin
                rb_reg.meas_clock_period_code <= 2'h0;
            end
        end
    end

    // Echo image for the next frame shows readback values from the last cycle start, refcell code unlifted
    logic [`SCFD_FRAME_BITS-1:0] echo_next;
    always_comb begin
        echo_next = 64'h0;
        echo_next[`SCFD_BIT_CLAMP_ON] = rb_reg.clamp_on;
        echo_next[`SCFD_BIT_CLAMP_REF] = rb_reg.clamp_ref_pick;
        echo_next[`SCFD_BIT_CLAMP_SHAPE] = rb_reg.clamp_range_shape;
        echo_next[`SCFD_CCS_HI:`SCFD_CCS_LO] = rb_reg.clean_current_pick;
        echo_next[`SCFD_GAIN_HI:`SCFD_GAIN_LO] = rb_reg.scaling_gain_pick;
        echo_next[`SCFD_CAP_HI:`SCFD_CAP_LO] = rb_reg.comp_capacitance_code;
        echo_next[`SCFD_MCP_HI:`SCFD_MCP_LO] = rb_reg.meas_clock_period_code;
        echo_next[`SCFD_BIT_HB_TH] = rb_reg.heater_batt_threshold_pick;
        echo_next[`SCFD_RCP_HI:`SCFD_RCP_LO] = rb_reg.refcell_pulse_len;
        // Mode bit is live: it acts at once, not at cycle start
        echo_next[`SCFD_BIT_SYNC] = sync_reg;
        echo_next[`SCFD_BGP_HI:`SCFD_BGP_LO] = rb_reg.bandgap_pulse_len;
        echo_next[`SCFD_BIT_CB1] = 1'b1;
        echo_next[`SCFD_BIT_CB0] = 1'b0;
        echo_next[`SCFD_HBFT_HI:`SCFD_HBFT_LO] = hbft_reg;
        echo_next[`SCFD_RPP_HI:`SCFD_RPP_LO] = rb_reg.refpin_pulse_len;
        echo_next[`SCFD_BIT_FET_B] = fet_b_en_reg;
        echo_next[`SCFD_BIT_FET_A] = fet_a_en_reg;
    end
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            echo_reg <= 64'h0;
        end else if (cs_sync_reg[1]) begin
            echo_reg <= echo_next;
        end
    end

    // ------------------------------------------------------------
    // Protection FET drivers
    // ------------------------------------------------------------
    logic fet_a_reg;
    logic fet_b_reg;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fet_a_reg <= 1'b0;
            fet_b_reg <= 1'b0;
        end else begin
            fet_a_reg <= fet_a_en_reg & ~batt_short;
            fet_b_reg <= fet_b_en_reg & ~batt_short;
        end
    end

    assign applied_cfg = appl_reg;
    assign readback_cfg = rb_reg;
    assign heater_batt_fault_time = hbft_reg;
    assign sync_mode_select = sync_reg;
    assign protect_fet_a_on = fet_a_reg;
    assign protect_fet_b_on = fet_b_reg;
    assign fault_wipe = wipe_reg;
    assign confirm_error = cb_err_reg;
    assign cycle_abort = abort_reg;
    assign sync_cycle_start = sync_start_reg;
endmodule

// ===== verification/scfd_frame_decode_properties.sv
// Port assertions for the configuration frame decoder
`timescale 1ns/1ns
module scfd_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_low,
    input wire logic cycle_start,
    input wire logic sensor_batt_short,
    input wire scfd_pkg::scfd_cfg_t applied_cfg,
    input wire scfd_pkg::scfd_cfg_t readback_cfg,
    input wire logic sync_mode_select,
    input wire logic protect_fet_a_on,
    input wire logic protect_fet_b_on,
    input wire logic fault_wipe,
    input wire logic confirm_error,
    input wire logic cycle_abort,
    input wire logic sync_cycle_start
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Short must outlast the two-flop sync and the output flop
    sequence s_short;
        sensor_batt_short [*4];
    endsequence
    property p_defer;
        !$stable(applied_cfg) |-> $past(cycle_start || sync_cycle_start);
    endproperty
    a_defer: assert property (p_defer) else $error("applied moved");
    property p_rb;
        !$stable(readback_cfg) |-> $past(cycle_start || sync_cycle_start);
    endproperty
    a_rb: assert property (p_rb) else $error("readback moved");
    property p_wipe;
        fault_wipe |-> chip_select_low ##1 !fault_wipe;
    endproperty
    a_wipe: assert property (p_wipe) else $error("wipe pulse");
    property p_cerr;
        confirm_error |-> chip_select_low ##1 !confirm_error;
    endproperty
    a_cerr: assert property (p_cerr) else $error("confirm pulse");
    property p_abort;
        cycle_abort |=> sync_mode_select && !cycle_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort pulse");
    property p_sync;
        sync_cycle_start |-> sync_mode_select
            ##1 readback_cfg.meas_clock_period_code == 2'h0;
    endproperty
    a_sync: assert property (p_sync) else $error("sync start");
    property p_fet;
        s_short |-> !protect_fet_a_on && !protect_fet_b_on;
    endproperty
    a_fet: assert property (p_fet) else $error("fet on");
    property p_lift;
        |applied_cfg.refcell_pulse_len
            |-> applied_cfg.refcell_pulse_len > 7'h18;
    endproperty
    a_lift: assert property (p_lift) else $error("pulse short");
endmodule
bind scfd_frame_decode scfd_chk i_chk (
    .clk(clk), .rst_n(rst_n), .chip_select_low(chip_select_low),
    .cycle_start(cycle_start), .sensor_batt_short(sensor_batt_short),
    .applied_cfg(applied_cfg), .readback_cfg(readback_cfg),
    .sync_mode_select(sync_mode_select), .fault_wipe(fault_wipe),
    .protect_fet_a_on(protect_fet_a_on), .cycle_abort(cycle_abort),
    .protect_fet_b_on(protect_fet_b_on), .confirm_error(confirm_error),
    .sync_cycle_start(sync_cycle_start)
);

// ===== verification/scfd_spi_host.sv
// Host serial master that shifts configuration frames
`timescale 1ns/1ns
module scfd_spi_host (
    output logic sclk,
    output logic chip_select_low,
    output logic sdi,
    input wire logic sdo
);
    logic [63:0] echo_reg;
    initial begin
        sclk = 1'b0;
        // A definite rising edge clears the receiver's bit count
        chip_select_low = 1'b0;
        sdi = 1'b1;
        echo_reg = 64'h0;
        #1 chip_select_low = 1'b1;
    end
    // Clock stands low between frames; data flips so stale bits never pass
    task automatic send(input logic [63:0] frame, input int nbits);
        // Keep clear of the system clock edge that called us
        #13;
        chip_select_low = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = frame[63 - i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
            echo_reg = {echo_reg[62:0], sdo};
        end
        #40 chip_select_low = 1'b1;
        sdi = ~sdi;
    endtask
endmodule

// ===== verification/sensor_spi_config_frame_decode_test.sv
// Self-checking bench for the configuration frame decoder
`timescale 1ns/1ns
module sensor_spi_config_frame_decode_test;
    typedef struct packed {
        logic [63:0] frame;
        logic pump;
        logic [1:0] fets;
    } scfd_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cycle_start = 1'b0;
    logic pump_current_source = 1'b0;
    logic sync_input = 1'b0;
    logic sensor_batt_short = 1'b0;
    logic sclk, chip_select_low, sdi, sdo;
    logic sync_mode_select, protect_fet_a_on, protect_fet_b_on;
    logic fault_wipe, confirm_error, cycle_abort, sync_cycle_start;
    logic [1:0] heater_batt_fault_time;
    scfd_pkg::scfd_cfg_t applied_cfg, readback_cfg, pend, rb, ap, def;
    int error_cnt, samples_checked, wipe_cnt, cerr_cnt, abort_cnt, base;
    int sync_cnt;
    scfd_row_t r;
    // Confirm pattern 2'b10 in bits 15:14 of every row
    scfd_row_t rows [4] = '{
        '{64'h0007_d556_8555_bdff, 1'b0, 2'h3},
        '{64'h0000_2a01_182a_8a80, 1'b1, 2'h2},
        '{64'h0005_7f03_197f_9740, 1'b0, 2'h1},
        '{64'h0000_00fc_0000_8000, 1'b0, 2'h0}
    };
    always #25 clk = ~clk;
    scfd_frame_decode i_scfd_frame_decode (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .chip_select_low(chip_select_low), .cycle_start(cycle_start),
        .pump_current_source(pump_current_source),
        .sync_input(sync_input), .sensor_batt_short(sensor_batt_short),
        .applied_cfg(applied_cfg), .readback_cfg(readback_cfg),
        .heater_batt_fault_time(heater_batt_fault_time),
        .sync_mode_select(sync_mode_select), .fault_wipe(fault_wipe),
        .protect_fet_a_on(protect_fet_a_on), .cycle_abort(cycle_abort),
        .protect_fet_b_on(protect_fet_b_on), .confirm_error(confirm_error),
        .sync_cycle_start(sync_cycle_start)
    );
    scfd_spi_host i_scfd_spi_host (
        .sclk(sclk), .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo)
    );
    // Pulses last a full cycle, so the falling edge counts each once
    always @(negedge clk) begin
        if (fault_wipe === 1'b1)
            wipe_cnt++;
        if (confirm_error === 1'b1)
            cerr_cnt++;
        if (cycle_abort === 1'b1)
            abort_cnt++;
        if (sync_cycle_start === 1'b1)
            sync_cnt++;
    end
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic void take(input logic [63:0] f, input logic pump);
        pend.clamp_on = f[50];
        if (!pump) begin
            pend.clamp_ref_pick = f[49];
            pend.clamp_range_shape = f[48];
            pend.comp_capacitance_code = f[39:34];
        end
        pend.clean_current_pick = f[46:43];
        pend.scaling_gain_pick = f[42:40];
        pend.meas_clock_period_code = f[33:32];
        pend.heater_batt_threshold_pick = f[31];
        pend.refcell_pulse_len = f[30:24];
        pend.bandgap_pulse_len = f[22:16];
        pend.refpin_pulse_len = f[10:8];
    endfunction
    task automatic frame(input logic [63:0] f, input int n);
        @(posedge clk);
        i_scfd_spi_host.send(f, n);
        repeat (8) @(posedge clk);
        if (n == 64) begin
            check("echo", 64'({i_scfd_spi_host.echo_reg[46:40],
                i_scfd_spi_host.echo_reg[15:14]}),
                64'({rb.clean_current_pick, rb.scaling_gain_pick, 2'b10}));
            take(f, pump_current_source);
        end
    endtask
    task automatic start(input logic synced);
        @(posedge clk);
        if (synced)
            sync_input <= 1'b1;
        else
            cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        repeat (6) @(posedge clk);
        sync_input <= 1'b0;
        rb = pend;
        if (synced)
            rb.meas_clock_period_code = 2'h0;
        ap = rb;
        if (|ap.refcell_pulse_len && ap.refcell_pulse_len < 7'h19)
            ap.refcell_pulse_len = 7'h19;
        @(negedge clk);
        check("readback", 64'(readback_cfg), 64'(rb));
        check("applied", 64'(applied_cfg), 64'(ap));
    endtask
    task automatic set_short(input logic v, input logic [1:0] e);
        @(posedge clk);
        sensor_batt_short <= v;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("fets", 64'({protect_fet_b_on, protect_fet_a_on}),
            64'(e));
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        pend = def;
        rb = def;
        @(negedge clk);
        check("rst_rb", 64'(readback_cfg), 64'(def));
        check("rst_ap", 64'(applied_cfg), 64'(def));
        check("rst_mode", 64'(sync_mode_select), 64'h0);
    endtask
    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end
    initial begin
        def = '0;
        def.comp_capacitance_code = 6'h3f;
        do_reset();
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk);
            pump_current_source <= r.pump;
            repeat (4) @(posedge clk);
            base = wipe_cnt;
            frame(r.frame, 64);
            check("wipe", 64'(wipe_cnt - base), 64'(r.frame[47]));
            check("held", 64'(readback_cfg), 64'(rb));
            start(1'b0);
            check("ftime", 64'(heater_batt_fault_time),
                64'(r.frame[12:11]));
            check("fets", 64'({protect_fet_b_on, protect_fet_a_on}),
                64'(r.fets));
        end
        frame(64'hffff_ffff_ffff_ffff, 40);
        start(1'b0);
        base = cerr_cnt;
        frame(64'h0000_00fc_0000_4000, 64);
        check("cerr", 64'(cerr_cnt - base), 64'h1);
        set_short(1'b1, 2'h0);
        frame(64'h0000_00fc_0000_80c0, 64);
        start(1'b0);
        set_short(1'b1, 2'h0);
        set_short(1'b0, 2'h3);
        set_short(1'b1, 2'h0);
        base = abort_cnt;
        frame(64'h0000_00ff_0080_8000, 64);
        check("abort", 64'(abort_cnt - base), 64'h1);
        check("mode", 64'(sync_mode_select), 64'h1);
        @(posedge clk);
        cycle_start <= 1'b1;
        @(posedge clk);
        cycle_start <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("idle", 64'(readback_cfg), 64'(rb));
        base = sync_cnt;
        start(1'b1);
        check("sync_start", 64'(sync_cnt - base), 64'h1);
        do_reset();
        end_sim();
    end
endmodule
